/* etc_ctrl.sv */
// event triggered transfer controller, normal mode with chaining
// Contract
// - source step field b'10 increments source
// - destination step field b'10 increments destination
// - transfer kind b'00 means normal mode
// - unit size b'00 moves one byte
// - block side bit 0 selects destination; the bit is decoded but unused, block mode is not built
// - chain bit set chains next block
// - irq select 0 interrupts at count end
// - nmi mode 0 suspends on nmi
// - count word sets number of transfers
// - data read from source pointer
// - data written to destination pointer
// - base register gives upper sixteen bits
// - enable bit set lets source activate
// - start address is base plus vector
// - mode, count, source, destination at fixed offsets
`timescale 1ns/10ps
`default_nettype none
module etc_ctrl (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // register slave
    input wire logic [31:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // memory master
    output logic MEM_REQ,
    output etc_pkg::etc_mem_s MEM_CMD,
    input wire logic [31:0] MEM_RDATA,
    input wire logic MEM_ACK,
    // events
    input wire logic [7:0] IRQ_SRC,
    input wire logic NMI,
    // cpu interrupt
    output logic CPU_IRQ,
    output logic [2:0] CPU_IRQ_SRC
);
    etc_pkg::etc_state_e state_ff;
    etc_pkg::etc_state_e nxt_state;
    etc_pkg::etc_mem_s acc;
    etc_pkg::etc_mem_s cmd_ff;
    logic acc_en;
    logic req_ff;
    logic ack;
    logic [7:0] enable;
    logic [15:0] base;
    logic [7:0] src_q_ff;
    logic [7:0] pend_ff;
    logic [7:0] pend_clr;
    logic [7:0] en_clr;
    logic [2:0] cur_ff;
    logic [31:0] rf_ff;
    logic [15:0] mode_ff;
    logic [15:0] cnt_ff;
    logic [31:0] src_ff;
    logic [31:0] dst_ff;
    logic [31:0] data_ff;
    logic irq_ff;
    logic [2:0] irq_src_ff;
    logic [1:0] src_step;
    logic [1:0] dst_step;
    logic [1:0] kind;
    logic [1:0] usize;
    logic block_side;
    logic chain;
    logic irq_each;
    logic nmi_mode;
    logic bad_kind;
    logic nmi_hold;
    logic count_end;
    logic fin;

    // mode word decode
    assign src_step = mode_ff[etc_pkg::SRC_STEP_LO +: 2];
    assign dst_step = mode_ff[etc_pkg::DST_STEP_LO +: 2];
    assign kind = mode_ff[etc_pkg::KIND_LO +: 2];
    assign usize = mode_ff[etc_pkg::SIZE_LO +: 2];
    // block side only matters in block mode, which is not built
    assign block_side = mode_ff[etc_pkg::BLOCK_SIDE_BIT];
    assign chain = mode_ff[etc_pkg::CHAIN_BIT];
    assign irq_each = mode_ff[etc_pkg::IRQ_EACH_BIT];
    assign nmi_mode = mode_ff[etc_pkg::NMI_MODE_BIT];
    assign bad_kind = kind != etc_pkg::KIND_NORMAL;
    assign nmi_hold = NMI & ~nmi_mode;
    assign count_end = cnt_ff == 16'h0000;
    assign ack = req_ff & MEM_ACK;
    assign fin = state_ff == etc_pkg::S_END && !chain;

    assign MEM_REQ = req_ff;
    assign MEM_CMD = cmd_ff;
    assign CPU_IRQ = irq_ff;
    assign CPU_IRQ_SRC = irq_src_ff;

    etc_regs u_regs (
        .clk(MCLK),
        .rst(RESET),
        .address(AVS_ADDRESS),
        .read(AVS_READ),
        .write(AVS_WRITE),
        .writedata(AVS_WRITEDATA),
        .readdata(AVS_READDATA),
        .waitrequest(AVS_WAITREQUEST),
        .set_susp(state_ff == etc_pkg::S_DST && ack && nmi_hold && !bad_kind),
        .set_bad(state_ff == etc_pkg::S_DST && ack && bad_kind),
        .en_clr(en_clr),
        .busy(state_ff != etc_pkg::S_IDLE),
        .cur_src(cur_ff),
        .enable(enable),
        .base(base)
    );

    // rising edge of an enabled source makes it pending
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            src_q_ff <= 8'h00;
        end else begin
            src_q_ff <= IRQ_SRC & enable;
        end
    end

    always_comb begin
        pend_clr = 8'h00;
        if (fin || (state_ff == etc_pkg::S_DST && ack && bad_kind)) begin
            pend_clr[cur_ff] = 1'b1;
        end
        en_clr = 8'h00;
        if (fin && count_end && !irq_each) begin
            en_clr[cur_ff] = 1'b1;
        end
    end

    // new event wins over clear
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pend_ff <= 8'h00;
        end else begin
            pend_ff <= (pend_ff & ~pend_clr) | (IRQ_SRC & enable & ~src_q_ff);
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cur_ff <= 3'h0;
        end else if (state_ff == etc_pkg::S_IDLE && |pend_ff) begin
            cur_ff <= etc_pkg::etc_first(pend_ff);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            etc_pkg::S_IDLE: begin
                if (|pend_ff) nxt_state = etc_pkg::S_VEC;
            end
            etc_pkg::S_VEC: if (ack) nxt_state = etc_pkg::S_MODE;
            etc_pkg::S_MODE: if (ack) nxt_state = etc_pkg::S_CNT;
            etc_pkg::S_CNT: if (ack) nxt_state = etc_pkg::S_SRC;
            etc_pkg::S_SRC: if (ack) nxt_state = etc_pkg::S_DST;
            etc_pkg::S_DST: begin
                if (ack) nxt_state = (bad_kind || nmi_hold) ? etc_pkg::S_IDLE : etc_pkg::S_DRD;
            end
            etc_pkg::S_DRD: if (ack) nxt_state = etc_pkg::S_DWR;
            etc_pkg::S_DWR: if (ack) nxt_state = etc_pkg::S_WCNT;
            etc_pkg::S_WCNT: if (ack) nxt_state = etc_pkg::S_WSRC;
            etc_pkg::S_WSRC: if (ack) nxt_state = etc_pkg::S_WDST;
            etc_pkg::S_WDST: if (ack) nxt_state = etc_pkg::S_END;
            etc_pkg::S_END: nxt_state = chain ? etc_pkg::S_MODE : etc_pkg::S_IDLE;
            default: nxt_state = etc_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_ff <= etc_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // memory access wanted in each state except idle and end
    always_comb begin
        acc_en = 1'b1;
        acc.we = 1'b0;
        acc.size = etc_pkg::SIZE_LONG;
        acc.addr = 32'h00000000;
        acc.wdata = 32'h00000000;
        case (state_ff)
            etc_pkg::S_VEC: begin
                acc.size = etc_pkg::SIZE_WORD;
                acc.addr = etc_pkg::VEC_BASE + {28'h0000000, cur_ff, 1'b0};
            end
            etc_pkg::S_MODE: begin
                acc.size = etc_pkg::SIZE_WORD;
                acc.addr = rf_ff + etc_pkg::OFS_MODE;
            end
            etc_pkg::S_CNT: begin
                acc.size = etc_pkg::SIZE_WORD;
                acc.addr = rf_ff + etc_pkg::OFS_COUNT;
            end
            etc_pkg::S_SRC: acc.addr = rf_ff + etc_pkg::OFS_SRC;
            etc_pkg::S_DST: acc.addr = rf_ff + etc_pkg::OFS_DST;
            etc_pkg::S_DRD: begin
                acc.size = usize;
                acc.addr = src_ff;
            end
            etc_pkg::S_DWR: begin
                acc.we = 1'b1;
                acc.size = usize;
                acc.addr = dst_ff;
                acc.wdata = data_ff;
            end
            etc_pkg::S_WCNT: begin
                acc.we = 1'b1;
                acc.size = etc_pkg::SIZE_WORD;
                acc.addr = rf_ff + etc_pkg::OFS_COUNT;
                acc.wdata = {16'h0000, cnt_ff};
            end
            etc_pkg::S_WSRC: begin
                acc.we = 1'b1;
                acc.addr = rf_ff + etc_pkg::OFS_SRC;
                acc.wdata = src_ff;
            end
            etc_pkg::S_WDST: begin
                acc.we = 1'b1;
                acc.addr = rf_ff + etc_pkg::OFS_DST;
                acc.wdata = dst_ff;
            end
            default: acc_en = 1'b0;
        endcase
    end

    // request held from flops until acknowledged
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            req_ff <= 1'b0;
            cmd_ff <= '0;
        end else if (ack) begin
            req_ff <= 1'b0;
        end else if (!req_ff && acc_en) begin
            req_ff <= 1'b1;
            cmd_ff <= acc;
        end
    end

    // info block working copy
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            rf_ff <= 32'h00000000;
            mode_ff <= 16'h0000;
            cnt_ff <= 16'h0000;
            src_ff <= 32'h00000000;
            dst_ff <= 32'h00000000;
            data_ff <= 32'h00000000;
        end else begin
            case (state_ff)
                etc_pkg::S_VEC: if (ack) rf_ff <= {base, MEM_RDATA[15:0]};
                etc_pkg::S_MODE: if (ack) mode_ff <= MEM_RDATA[15:0];
                etc_pkg::S_CNT: if (ack) cnt_ff <= MEM_RDATA[15:0];
                etc_pkg::S_SRC: if (ack) src_ff <= MEM_RDATA;
                etc_pkg::S_DST: if (ack) dst_ff <= MEM_RDATA;
                etc_pkg::S_DRD: if (ack) data_ff <= MEM_RDATA;
                etc_pkg::S_DWR: begin
                    if (ack) begin
                        cnt_ff <= cnt_ff - 16'h0001;
                        src_ff <= etc_pkg::etc_step(src_ff, src_step, usize);
                        dst_ff <= etc_pkg::etc_step(dst_ff, dst_step, usize);
                    end
                end
                etc_pkg::S_END: if (chain) rf_ff <= rf_ff + etc_pkg::INFO_STRIDE;
                default: rf_ff <= rf_ff;
            endcase
        end
    end

    // cpu request at count end, or each transfer when selected
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            irq_ff <= 1'b0;
            irq_src_ff <= 3'h0;
        end else begin
            irq_ff <= state_ff == etc_pkg::S_END && (count_end || irq_each);
            if (state_ff == etc_pkg::S_END) begin
                irq_src_ff <= cur_ff;
            end
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    chk_irq_at_end: assert property (CPU_IRQ |-> $past(state_ff) == etc_pkg::S_END
        && ($past(cnt_ff) == 16'h0000 || $past(irq_each)))
        else $error("cpu request without count end");
    chk_src_inc: assert property (state_ff == etc_pkg::S_DWR && ack
        && src_step == etc_pkg::STEP_INC && usize == etc_pkg::SIZE_BYTE
        |=> src_ff == $past(src_ff) + 32'h1)
        else $error("source not incremented");
    chk_dst_inc: assert property (state_ff == etc_pkg::S_DWR && ack
        && dst_step == etc_pkg::STEP_INC && usize == etc_pkg::SIZE_BYTE
        |=> dst_ff == $past(dst_ff) + 32'h1)
        else $error("destination not incremented");
    chk_kind_abort: assert property (state_ff == etc_pkg::S_DST && ack && bad_kind
        |=> state_ff == etc_pkg::S_IDLE && !MEM_REQ)
        else $error("non-normal mode not refused");
    chk_byte_unit: assert property (MEM_REQ && state_ff == etc_pkg::S_DRD
        && usize == etc_pkg::SIZE_BYTE |-> MEM_CMD.size == etc_pkg::SIZE_BYTE)
        else $error("byte unit not requested");
    chk_nmi_stop: assert property (state_ff == etc_pkg::S_DST && ack && NMI && !nmi_mode
        |=> state_ff == etc_pkg::S_IDLE ##1 state_ff != etc_pkg::S_DRD)
        else $error("transfer not suspended by nmi");
    chk_data_path: assert property (MEM_REQ && state_ff == etc_pkg::S_DWR
        |-> MEM_CMD.we && MEM_CMD.addr == dst_ff)
        else $error("data written to wrong place");
    chk_src_read: assert property (MEM_REQ && state_ff == etc_pkg::S_DRD
        |-> !MEM_CMD.we && MEM_CMD.addr == src_ff)
        else $error("data read from wrong place");
    chk_start_addr: assert property (state_ff == etc_pkg::S_VEC && ack
        |=> rf_ff == {base, $past(MEM_RDATA[15:0])})
        else $error("start address badly formed");
    chk_cnt_ofs: assert property (MEM_REQ && state_ff == etc_pkg::S_CNT
        |-> MEM_CMD.addr == rf_ff + 32'h2)
        else $error("count fetched from wrong offset");
    chk_chain_next: assert property (state_ff == etc_pkg::S_END && chain
        |=> state_ff == etc_pkg::S_MODE && rf_ff == $past(rf_ff) + 32'h10)
        else $error("chain did not move to next block");
    chk_cnt_dec: assert property (state_ff == etc_pkg::S_DWR && ack
        |=> cnt_ff == $past(cnt_ff) - 16'h1 && state_ff == etc_pkg::S_WCNT)
        else $error("count not decremented");
    chk_idle_hold: assert property (state_ff == etc_pkg::S_IDLE && pend_ff == 8'h00
        |=> state_ff == etc_pkg::S_IDLE)
        else $error("started without enabled event");

    cov_chain: cover property (state_ff == etc_pkg::S_END && chain);
    cov_irq_end: cover property (CPU_IRQ && !$past(irq_each));
    cov_nmi: cover property (state_ff == etc_pkg::S_DST && ack && nmi_hold);
    cov_dst_block: cover property (state_ff == etc_pkg::S_DWR && !block_side);
endmodule
`default_nettype wire

/* etc_pkg.sv */
// constants, types and helpers for the event triggered transfer controller
package etc_pkg;
    // register word indices on the slave bus
    localparam logic [31:0] IDX_ENABLE = 32'hFFFF8703;
    localparam logic [31:0] IDX_BASE = 32'hFFFF8708;
    localparam logic [31:0] IDX_STATUS = 32'hFFFF870C;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [15:0] BASE_RST = 16'h0000;
    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_SUSP = 1;
    localparam int ST_BAD = 2;
    localparam int ST_SRC_LO = 4;
    // vector table of 16-bit pointers, one per source
    localparam logic [31:0] VEC_BASE = 32'h00000400;
    // info block layout
    localparam logic [31:0] OFS_MODE = 32'h00000000;
    localparam logic [31:0] OFS_COUNT = 32'h00000002;
    localparam logic [31:0] OFS_SRC = 32'h00000008;
    localparam logic [31:0] OFS_DST = 32'h0000000C;
    localparam logic [31:0] INFO_STRIDE = 32'h00000010;
    // mode word fields
    localparam int SRC_STEP_LO = 14;
    localparam int DST_STEP_LO = 12;
    localparam int KIND_LO = 10;
    localparam int SIZE_LO = 8;
    localparam int BLOCK_SIDE_BIT = 7;
    localparam int CHAIN_BIT = 6;
    localparam int IRQ_EACH_BIT = 5;
    localparam int NMI_MODE_BIT = 4;
    localparam logic [1:0] STEP_INC = 2'h2;
    localparam logic [1:0] STEP_DEC = 2'h3;
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    typedef struct packed {
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } etc_mem_s;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_VEC = 4'h1, S_MODE = 4'h2, S_CNT = 4'h3,
        S_SRC = 4'h4, S_DST = 4'h5, S_DRD = 4'h6, S_DWR = 4'h7,
        S_WCNT = 4'h8, S_WSRC = 4'h9, S_WDST = 4'hA, S_END = 4'hB
    } etc_state_e;

    // address after one unit, by step mode and unit size
    function automatic logic [31:0] etc_step(input logic [31:0] a, input logic [1:0] md,
                                             input logic [1:0] sz);
        logic [31:0] n;
        n = (sz == SIZE_WORD) ? 32'h2 : (sz == SIZE_LONG) ? 32'h4 : 32'h1;
        case (md)
            STEP_INC: etc_step = a + n;
            STEP_DEC: etc_step = a - n;
            default: etc_step = a;
        endcase
    endfunction

    // lowest set bit wins
    function automatic logic [2:0] etc_first(input logic [7:0] v);
        etc_first = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                etc_first = i[2:0];
            end
        end
    endfunction
endpackage

/* etc_regs.sv */
// slave register file for the transfer controller
`timescale 1ns/10ps
`default_nettype none
module etc_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // slave bus
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // controller side
    input wire logic set_susp,
    input wire logic set_bad,
    input wire logic [7:0] en_clr,
    input wire logic busy,
    input wire logic [2:0] cur_src,
    output logic [7:0] enable,
    output logic [15:0] base
);
    logic done_ff;
    logic [31:0] rdata_ff;
    logic [7:0] en_ff;
    logic [15:0] base_ff;
    logic susp_ff;
    logic bad_ff;
    logic wr_ok;

    // one wait state on every access
    assign waitrequest = (read | write) & ~done_ff;
    assign wr_ok = write & done_ff;
    assign readdata = rdata_ff;
    assign enable = en_ff;
    assign base = base_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (read | write) & ~done_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else if (read & ~done_ff) begin
            case (address)
                etc_pkg::IDX_ENABLE: rdata_ff <= {24'h000000, en_ff};
                etc_pkg::IDX_BASE: rdata_ff <= {16'h0000, base_ff};
                etc_pkg::IDX_STATUS: begin
                    rdata_ff <= 32'h00000000;
                    rdata_ff[etc_pkg::ST_BUSY] <= busy;
                    rdata_ff[etc_pkg::ST_SUSP] <= susp_ff;
                    rdata_ff[etc_pkg::ST_BAD] <= bad_ff;
                    rdata_ff[etc_pkg::ST_SRC_LO +: 3] <= cur_src;
                end
                default: rdata_ff <= 32'h00000000;
            endcase
        end
    end

    // software write wins over end-of-count clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_ff <= etc_pkg::ENABLE_RST;
            base_ff <= etc_pkg::BASE_RST;
        end else begin
            if (wr_ok && address == etc_pkg::IDX_ENABLE) begin
                en_ff <= writedata[7:0];
            end else begin
                en_ff <= en_ff & ~en_clr;
            end
            if (wr_ok && address == etc_pkg::IDX_BASE) begin
                base_ff <= writedata[15:0];
            end
        end
    end

    // sticky flags, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            susp_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            if (set_susp) begin
                susp_ff <= 1'b1;
            end else if (wr_ok && address == etc_pkg::IDX_STATUS && writedata[etc_pkg::ST_SUSP]) begin
                susp_ff <= 1'b0;
            end
            if (set_bad) begin
                bad_ff <= 1'b1;
            end else if (wr_ok && address == etc_pkg::IDX_STATUS && writedata[etc_pkg::ST_BAD]) begin
                bad_ff <= 1'b0;
            end
        end
    end

    chk_base_load: assert property (@(posedge clk) disable iff (rst)
        wr_ok && address == etc_pkg::IDX_BASE |=> base_ff == $past(writedata[15:0]))
        else $error("base register did not load");
endmodule
`default_nettype wire

/* etc_mem_model.sv */
// memory model on the far side of the controller master port
`timescale 1ns/10ps
`default_nettype none
module etc_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // memory port
    input wire logic req,
    input wire etc_pkg::etc_mem_s cmd,
    output logic [31:0] rdata,
    output logic ack,
    // wait states before each ack
    input wire logic [3:0] delay
);
    logic [7:0] mem [logic [31:0]];
    logic [3:0] wait_ff;
    // most significant byte at the lowest address
    function automatic logic [31:0] get(input logic [31:0] a, input int n);
        get = 32'h0;
        for (int i = 0; i < n; i++) begin
            get = {get[23:0], mem.exists(a + i) ? mem[a + i] : 8'h00};
        end
    endfunction
    task automatic put(input logic [31:0] a, input logic [31:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            mem[a + i] = d[8 * (n - 1 - i) +: 8];
        end
    endtask
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            wait_ff <= 4'h0;
            rdata <= 32'h0;
        end else if (req && !ack && wait_ff >= delay) begin
            ack <= 1'b1;
            wait_ff <= 4'h0;
            rdata <= get(cmd.addr, 1 << cmd.size);
            if (cmd.we) begin
                put(cmd.addr, cmd.wdata, 1 << cmd.size);
            end
        end else begin
            ack <= 1'b0;
            wait_ff <= (req && !ack) ? wait_ff + 4'h1 : 4'h0;
            // stale data must not look valid
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the transfer controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] address = 32'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic mem_req;
    etc_pkg::etc_mem_s mem_cmd;
    logic [31:0] mem_rdata;
    logic mem_ack;
    logic [7:0] irq_src = 8'h00;
    logic nmi = 1'b0;
    logic cpu_irq;
    logic [2:0] cpu_irq_src;
    logic [3:0] delay = 4'h0;
    logic [31:0] q;
    int err_total = 0;
    int n_checks = 0;
    int irq_n = 0;
    int cyc = 0;

    always #2.5 mclk = ~mclk;
    etc_ctrl DUT (.MCLK(mclk), .RESET(reset), .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .MEM_REQ(mem_req),
        .MEM_CMD(mem_cmd), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .IRQ_SRC(irq_src), .NMI(nmi),
        .CPU_IRQ(cpu_irq), .CPU_IRQ_SRC(cpu_irq_src));
    etc_mem_model PART (.clk(mclk), .rst(reset), .req(mem_req), .cmd(mem_cmd), .rdata(mem_rdata),
        .ack(mem_ack), .delay(delay));

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cpu_irq === 1'b1) begin
            irq_n <= irq_n + 1;
        end
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        address <= a;
        wdata <= d;
        write <= w;
        read <= !w;
        @(posedge mclk);
        while (waitreq !== 1'b0) begin
            @(posedge mclk);
        end
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic fire(input int b);
        irq_src[b] <= 1'b1;
        repeat (2) @(posedge mclk);
        irq_src[b] <= 1'b0;
    endtask

    // waits on busy; only the cycle ceiling ends a hang
    task automatic wait_done();
        repeat (6) @(posedge mclk);
        q = 32'h1;
        while (q[etc_pkg::ST_BUSY] !== 1'b0) begin
            bus(1'b0, etc_pkg::IDX_STATUS, 32'h0);
        end
    endtask

    task automatic t_regs();
        bus(1'b0, etc_pkg::IDX_ENABLE, 32'h0);
        chk(q, {24'h0, etc_pkg::ENABLE_RST});
        bus(1'b0, etc_pkg::IDX_BASE, 32'h0);
        chk(q, {16'h0, etc_pkg::BASE_RST});
        bus(1'b1, etc_pkg::IDX_BASE, 32'h0000FFFF);
        bus(1'b1, etc_pkg::IDX_ENABLE, 32'h00000020);
        bus(1'b0, etc_pkg::IDX_BASE, 32'h0);
        chk(q, 32'h0000FFFF);
        bus(1'b1, 32'h00000010, 32'hFFFFFFFF);
        bus(1'b0, 32'h00000010, 32'h0);
        chk(q, 32'h0);
        $display("test regs done");
    endtask

    // two chained blocks, three activations, memory slowing down
    task automatic t_chain();
        logic [31:0] m;
        PART.put(etc_pkg::VEC_BASE + 32'hA, 32'hE000, 2);
        PART.put(32'hFFFFE000, 32'hA040, 2);
        PART.put(32'hFFFFE002, 32'h3, 2);
        PART.put(32'hFFFFE008, 32'h1000, 4);
        PART.put(32'hFFFFE00C, 32'h2000, 4);
        PART.put(32'hFFFFE010, 32'hA000, 2);
        PART.put(32'hFFFFE012, 32'h3, 2);
        PART.put(32'hFFFFE018, 32'h1100, 4);
        PART.put(32'hFFFFE01C, 32'h2100, 4);
        PART.put(32'h1000, 32'h112233, 3);
        PART.put(32'h1100, 32'h445566, 3);
        PART.put(32'h2000, 32'hEEEEEEEE, 4);
        PART.put(32'h2100, 32'hEEEEEEEE, 4);
        for (int k = 0; k < 3; k++) begin
            delay <= 4'(2 * k);
            fire(5);
            wait_done();
            m = ~(32'hFFFFFFFF >> (8 * (k + 1)));
            chk(PART.get(32'h2000, 4), (32'h112233EE & m) | (32'hEEEEEEEE & ~m));
            chk(PART.get(32'h2100, 4), (32'h445566EE & m) | (32'hEEEEEEEE & ~m));
            chk(PART.get(32'hFFFFE002, 2), 32'(2 - k));
            chk(PART.get(32'hFFFFE008, 4), 32'(32'h1001 + k));
            chk(PART.get(32'hFFFFE01C, 4), 32'(32'h2101 + k));
            chk({31'h0, irq_n != 0}, {31'h0, k == 2});
        end
        chk({29'h0, cpu_irq_src}, 32'h5);
        bus(1'b0, etc_pkg::IDX_ENABLE, 32'h0);
        chk(q, 32'h0);
        $display("test chain done");
    endtask

    task automatic t_fault();
        PART.put(32'hFFFFE000, 32'hA000, 2);
        PART.put(32'hFFFFE002, 32'h1, 2);
        PART.put(32'h1003, 32'h77, 1);
        PART.put(32'h1004, 32'h55, 1);
        PART.put(32'h2004, 32'hEE, 1);
        bus(1'b1, etc_pkg::IDX_ENABLE, 32'h00000020);
        fire(3);
        repeat (20) @(posedge mclk);
        chk(PART.get(32'h2003, 1), 32'hEE);
        nmi <= 1'b1;
        fire(5);
        repeat (60) @(posedge mclk);
        bus(1'b0, etc_pkg::IDX_STATUS, 32'h0);
        chk({31'h0, q[etc_pkg::ST_SUSP]}, 32'h1);
        chk({29'h0, q[etc_pkg::ST_SRC_LO +: 3]}, 32'h5);
        chk(PART.get(32'h2003, 1), 32'hEE);
        nmi <= 1'b0;
        wait_done();
        chk(PART.get(32'h2003, 1), 32'h77);
        PART.put(32'hFFFFE000, 32'hA400, 2);
        bus(1'b1, etc_pkg::IDX_ENABLE, 32'h00000020);
        fire(5);
        wait_done();
        chk(PART.get(32'h2004, 1), 32'hEE);
        bus(1'b0, etc_pkg::IDX_STATUS, 32'h0);
        chk({31'h0, q[etc_pkg::ST_BAD]}, 32'h1);
        $display("test fault done");
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_chain();
        t_fault();
        finish_test();
    end
endmodule
`default_nettype wire
